// ### halfbridge_fault_pkg.sv
/*
 * Shared constants and types for the half-bridge protection logic.
 * Assumes one 50 MHz clock and pins synchronised before use.
 */
//
// Contract
// - Mode input picks cycle limiting or latching overcurrent handling.
// - In cycle limit mode, overcurrent trims the gates instead of shutting down.
// - In cycle limit mode, a short detection latches that leg off in high impedance.
// - Each of the three legs limits and latches on its own.
// - Low-side overcurrent: low and high gates off until the next PWM cycle.
// - High-side overcurrent: high off, low on until the next PWM cycle.
// - Latching mode: no limiting, any overcurrent latches shutdown at once.
// - Warning output goes low above the warning temperature.
// - Above shutdown temperature: thermal latch, all legs off, fault low.
// - Thermal latch clears only after every leg reset went low then high.
// - Power-on clearing resets overcurrent latches and holds legs off.
// - Supply undervoltage: all legs off and fault low at once.
// - Undervoltage recovery is automatic once supplies are back.
// - Leg reset low forces both gates of that leg off.
// - Leg reset rising edge clears that leg's overcurrent latch.
// - Fault and warning pins encode normal, warning, shutdown, or both.
package halfbridge_fault_pkg;

    localparam int   NUM_LEGS         = 3;
    localparam int   SYNC_STAGES      = 2;
    localparam logic GATE_RESET       = 1'b0;
    localparam logic LATCH_RESET      = 1'b0;
    localparam logic FAULT_RESET      = 1'b1;
    localparam logic WARN_RESET       = 1'b0;
    localparam logic MODE_CYCLE_LIMIT = 1'b1;

    typedef enum logic {
        HEAT_NORMAL,
        HEAT_TRIPPED
    } heat_state_e;

endpackage

// ### leg_if.sv
/*
 * Per-leg carrier between the protection core and one half-bridge.
 * Assumes every input is already synchronised to clk_in.
 */
`timescale 1ns/1ps
interface leg_if;
    logic pwm_high;
    logic pwm_low;
    logic reset_n;
    logic cycle_start;
    logic oc_high;
    logic oc_low;
    logic short_hit;
    logic limit_mode;
    logic force_hiz;
    logic clear_oc;
    logic gate_high;
    logic gate_low;
    logic oc_latched;
    logic limiting;

    modport core (
        output pwm_high, pwm_low, reset_n, cycle_start, oc_high, oc_low,
               short_hit, limit_mode, force_hiz, clear_oc,
        input  gate_high, gate_low, oc_latched, limiting
    );
    modport leg (
        input  pwm_high, pwm_low, reset_n, cycle_start, oc_high, oc_low,
               short_hit, limit_mode, force_hiz, clear_oc,
        output gate_high, gate_low, oc_latched, limiting
    );
endinterface

// ### pin_sync.sv
/*
 * Multi-stage level synchroniser for asynchronous pins.
 * Assumes levels only; pulses shorter than one clock may be missed.
 */
`timescale 1ns/1ps
module pin_sync
    import halfbridge_fault_pkg::*;
#(
    parameter int WIDTH  = 1,
    parameter int STAGES = SYNC_STAGES
) (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] stage;
    } sync_state_s;

    sync_state_s st;
    sync_state_s next_st;

    if (STAGES < 2 || WIDTH < 1) begin : g_bad
        $error("pin_sync needs two stages and a width");
    end

    // stage 0 feeds only stage 1
    always_comb begin
        next_st       = st;
        next_st.stage = {st.stage[STAGES-2:0], pin_in};
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_out = st.stage[STAGES-1];
endmodule

// ### halfbridge_leg.sv
/*
 * One half-bridge: overcurrent limiting, latch, and gate steering.
 * Assumes synchronised inputs from the core over leg_if.
 */
`timescale 1ns/1ps
module halfbridge_leg
    import halfbridge_fault_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    leg_if.leg        link
);
    typedef struct packed {
        logic reset_prev;
        logic high_cut;
        logic low_cut;
        logic low_force;
        logic oc_latched;
        logic gate_high;
        logic gate_low;
    } leg_state_s;

    leg_state_s st;
    leg_state_s next_st;
    logic       rise;
    logic       trip;
    logic       hiz;

    always_comb begin
        next_st            = st;
        next_st.reset_prev = link.reset_n;
        rise = link.reset_n & ~st.reset_prev;
        // latching mode trips on either overcurrent hit, limit mode only on a short
        trip = link.limit_mode ? link.short_hit
                               : (link.oc_high | link.oc_low);
        if (link.clear_oc) begin
            next_st.oc_latched = 1'b0;
        end else if (trip) begin
            next_st.oc_latched = 1'b1;
        end else if (rise) begin
            next_st.oc_latched = 1'b0;
        end
        if (link.limit_mode) begin
            if (link.cycle_start) begin
                next_st.high_cut  = 1'b0;
                next_st.low_cut   = 1'b0;
                next_st.low_force = 1'b0;
            end
            // set after clear: a hit on the boundary is kept
            if (link.oc_low) begin
                next_st.high_cut = 1'b1;
                next_st.low_cut  = 1'b1;
            end
            if (link.oc_high) begin
                next_st.high_cut  = 1'b1;
                next_st.low_force = 1'b1;
            end
        end else begin
            next_st.high_cut  = 1'b0;
            next_st.low_cut   = 1'b0;
            next_st.low_force = 1'b0;
        end
        hiz = ~link.reset_n | link.force_hiz | next_st.oc_latched;
        // both commands at once drive neither gate unless low_force holds the low one: no shoot-through
        next_st.gate_high = ~hiz & link.pwm_high & ~link.pwm_low
                            & ~next_st.high_cut;
        next_st.gate_low  = ~hiz & ~next_st.low_cut
                            & (next_st.low_force
                               | (link.pwm_low & ~link.pwm_high));
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= '{reset_prev: 1'b0, high_cut: 1'b0, low_cut: 1'b0,
                    low_force: 1'b0, oc_latched: LATCH_RESET,
                    gate_high: GATE_RESET, gate_low: GATE_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign link.gate_high  = st.gate_high;
    assign link.gate_low   = st.gate_low;
    assign link.oc_latched = st.oc_latched;
    assign link.limiting   = st.high_cut | st.low_cut | st.low_force;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_low_oc;
        link.limit_mode && link.oc_low && !link.cycle_start
        |=> !link.gate_high && !link.gate_low;
    endproperty
    a_low_oc: assert property (p_low_oc)
        else $error("low-side hit left a gate on");

    property p_high_oc;
        link.limit_mode && link.oc_high && !link.oc_low && link.reset_n
        && !link.force_hiz && !link.short_hit && !link.clear_oc
        && !st.low_cut && !st.oc_latched
        |=> link.gate_low && !link.gate_high;
    endproperty
    a_high_oc: assert property (p_high_oc)
        else $error("high-side hit did not swap to low gate");

    property p_latch_mode;
        !link.limit_mode && (link.oc_high || link.oc_low) && !link.clear_oc
        |=> link.oc_latched && !link.gate_high && !link.gate_low;
    endproperty
    a_latch_mode: assert property (p_latch_mode)
        else $error("latching mode did not shut the leg");

    property p_short;
        link.limit_mode && link.short_hit && !link.clear_oc
        |=> link.oc_latched [*2];
    endproperty
    a_short: assert property (p_short)
        else $error("short did not latch the leg");

    property p_rise_clear;
        $rose(link.reset_n) && !trip && !link.clear_oc |=> !link.oc_latched;
    endproperty
    a_rise_clear: assert property (p_rise_clear)
        else $error("reset rising edge kept the latch");
endmodule

// ### halfbridge_fault_protection.sv
/*
 * Protection core for a three half-bridge power stage: pin sync,
 * thermal latch, undervoltage and power-on hold, fault reporting.
 * Assumes asynchronous pins from comparators and the controller; the
 * controller sees fault and warning as open-drain, low when driven.
 */
`timescale 1ns/1ps
module halfbridge_fault_protection
    import halfbridge_fault_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                reset_n_in,
    input  wire logic [NUM_LEGS-1:0] pwm_high_in,
    input  wire logic [NUM_LEGS-1:0] pwm_low_in,
    input  wire logic [NUM_LEGS-1:0] bridge_reset_n_in,
    input  wire logic                pwm_cycle_in,
    input  wire logic                cycle_limit_mode_in,
    input  wire logic [NUM_LEGS-1:0] oc_high_in,
    input  wire logic [NUM_LEGS-1:0] oc_low_in,
    input  wire logic [NUM_LEGS-1:0] short_hit_in,
    input  wire logic                temp_warn_in,
    input  wire logic                temp_shutdown_in,
    input  wire logic                supply_ok_in,
    input  wire logic                power_good_in,
    output logic      [NUM_LEGS-1:0] gate_high_out,
    output logic      [NUM_LEGS-1:0] gate_low_out,
    output logic      [NUM_LEGS-1:0] overcurrent_event_out,
    output logic      [NUM_LEGS-1:0] limiting_out,
    output logic                     thermal_shutdown_out,
    output logic                     undervoltage_guard_out,
    output logic                     fault_n_out,
    output logic                     fault_oe_out,
    output logic                     heat_warning_n_out,
    output logic                     heat_warning_oe_out
);
    localparam int PIN_BITS = 6 * NUM_LEGS + 6;

    typedef struct packed {
        heat_state_e         heat;
        logic                cycle_prev;
        logic [NUM_LEGS-1:0] went_low;
        logic [NUM_LEGS-1:0] came_back;
        logic                fault;
        logic                warn;
        logic                uv;
    } core_state_s;

    core_state_s st;
    core_state_s next_st;

    logic [NUM_LEGS-1:0] pwm_high_s;
    logic [NUM_LEGS-1:0] pwm_low_s;
    logic [NUM_LEGS-1:0] reset_s;
    logic [NUM_LEGS-1:0] oc_high_s;
    logic [NUM_LEGS-1:0] oc_low_s;
    logic [NUM_LEGS-1:0] short_s;
    logic                cycle_s;
    logic                mode_s;
    logic                warn_s;
    logic                hot_s;
    logic                supply_ok_s;
    logic                power_good_s;
    logic [NUM_LEGS-1:0] oc_vec;
    logic [NUM_LEGS-1:0] lim_vec;
    logic [NUM_LEGS-1:0] gh_vec;
    logic [NUM_LEGS-1:0] gl_vec;
    logic                por;
    logic                uv;
    logic                tripped;
    logic                all_off;
    logic                cycle_start;
    logic                force_hiz;
    logic                fault_cause;

    if (NUM_LEGS != 3) begin : g_bad_legs
        $error("protection core is built for three legs");
    end

    // every pin, including the mode strap, is treated as asynchronous
    pin_sync #(
        .WIDTH  (PIN_BITS),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .pin_in     ({pwm_high_in, pwm_low_in, bridge_reset_n_in,
                      oc_high_in, oc_low_in, short_hit_in,
                      pwm_cycle_in, cycle_limit_mode_in, temp_warn_in,
                      temp_shutdown_in, supply_ok_in, power_good_in}),
        .level_out  ({pwm_high_s, pwm_low_s, reset_s,
                      oc_high_s, oc_low_s, short_s,
                      cycle_s, mode_s, warn_s,
                      hot_s, supply_ok_s, power_good_s})
    );

    assign por         = ~power_good_s;
    assign uv          = ~supply_ok_s;
    assign tripped     = (st.heat == HEAT_TRIPPED);
    assign cycle_start = cycle_s & ~st.cycle_prev;
    // a hot reading blocks the legs before the latch registers
    assign force_hiz   = tripped | hot_s | uv | por;
    assign fault_cause = (|oc_vec) | force_hiz;

    for (genvar i = 0; i < NUM_LEGS; i++) begin : g_leg
        leg_if bus ();

        assign bus.pwm_high    = pwm_high_s[i];
        assign bus.pwm_low     = pwm_low_s[i];
        assign bus.reset_n     = reset_s[i];
        assign bus.cycle_start = cycle_start;
        assign bus.oc_high     = oc_high_s[i];
        assign bus.oc_low      = oc_low_s[i];
        assign bus.short_hit   = short_s[i];
        assign bus.limit_mode  = (mode_s == MODE_CYCLE_LIMIT);
        assign bus.force_hiz   = force_hiz;
        assign bus.clear_oc    = por;

        halfbridge_leg u_leg (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .link       (bus)
        );

        assign gh_vec[i]  = bus.gate_high;
        assign gl_vec[i]  = bus.gate_low;
        assign oc_vec[i]  = bus.oc_latched;
        assign lim_vec[i] = bus.limiting;

        property p_leg_reset;
            @(posedge clk_in) disable iff (!reset_n_in)
            !reset_s[i] |=> !gate_high_out[i] && !gate_low_out[i];
        endproperty
        a_leg_reset: assert property (p_leg_reset)
            else $error("leg driven while its reset is low");
    end

    always_comb begin
        next_st            = st;
        next_st.cycle_prev = cycle_s;
        next_st.uv         = uv | por;
        next_st.warn       = warn_s;
        next_st.fault      = fault_cause;
        case (st.heat)
            HEAT_NORMAL: begin
                next_st.went_low  = '0;
                next_st.came_back = '0;
                if (hot_s) begin
                    next_st.heat = HEAT_TRIPPED;
                end
            end
            HEAT_TRIPPED: begin
                // each leg must show low, then high, in that order
                next_st.went_low  = st.went_low | ~reset_s;
                next_st.came_back = st.came_back
                                    | (st.went_low & reset_s);
                if (&st.came_back && !hot_s) begin
                    next_st.heat = HEAT_NORMAL;
                end
            end
            default: begin
                next_st.heat = HEAT_TRIPPED;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= '{heat: HEAT_NORMAL, cycle_prev: 1'b0, went_low: '0,
                    came_back: '0, fault: FAULT_RESET, warn: WARN_RESET,
                    uv: FAULT_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign all_off                = ~(|gh_vec) & ~(|gl_vec);
    assign gate_high_out          = gh_vec;
    assign gate_low_out           = gl_vec;
    assign overcurrent_event_out  = oc_vec;
    assign limiting_out           = lim_vec;
    assign thermal_shutdown_out   = tripped;
    assign undervoltage_guard_out = st.uv;
    // open drain: enable pulls the line low, release lets it float high
    assign fault_n_out            = ~st.fault;
    assign fault_oe_out           = st.fault;
    assign heat_warning_n_out     = ~st.warn;
    assign heat_warning_oe_out    = st.warn;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_warning;
        warn_s |=> !heat_warning_n_out && heat_warning_oe_out;
    endproperty
    a_warning: assert property (p_warning)
        else $error("warning pin not low when hot");

    property p_thermal_trip;
        hot_s |=> thermal_shutdown_out && all_off && !fault_n_out;
    endproperty
    a_thermal_trip: assert property (p_thermal_trip)
        else $error("thermal shutdown did not block legs");

    property p_thermal_hold;
        tripped && st.went_low == '0 && reset_s == '1 |=> tripped;
    endproperty
    a_thermal_hold: assert property (p_thermal_hold)
        else $error("thermal latch left without reset pulses");

    property p_thermal_release;
        tripped ##1 !tripped |-> $past(reset_s) == '1 && !$past(hot_s);
    endproperty
    a_thermal_release: assert property (p_thermal_release)
        else $error("thermal latch cleared with a reset low");

    property p_power_on;
        por |=> oc_vec == '0 && all_off && undervoltage_guard_out;
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("power-on hold did not clear the legs");

    property p_undervoltage;
        uv |=> all_off && fault_oe_out && undervoltage_guard_out;
    endproperty
    a_undervoltage: assert property (p_undervoltage)
        else $error("undervoltage did not block legs");

    property p_uv_resume;
        !uv && !por && !tripped && !hot_s && oc_vec == '0
        |=> fault_n_out && !undervoltage_guard_out;
    endproperty
    a_uv_resume: assert property (p_uv_resume)
        else $error("no automatic recovery after undervoltage");

    property p_encoding;
        ##1 (fault_n_out == !$past(fault_cause))
            && (heat_warning_n_out == !$past(warn_s));
    endproperty
    a_encoding: assert property (p_encoding)
        else $error("fault or warning pin code wrong");

    property p_fault_held;
        |oc_vec |=> !fault_n_out;
    endproperty
    a_fault_held: assert property (p_fault_held)
        else $error("fault released while a leg is latched");

    property p_fault_pin;
        fault_oe_out == !fault_n_out
        && heat_warning_oe_out == !heat_warning_n_out;
    endproperty
    a_fault_pin: assert property (p_fault_pin)
        else $error("open-drain enable disagrees with level");

    c_thermal_cycle: cover property (tripped ##[1:40] !tripped);
    c_uv_event: cover property (uv ##1 !uv);
    c_oc_latch: cover property ($rose(|oc_vec));
    c_limiting: cover property ($rose(|lim_vec) ##[1:40] !(|lim_vec));
endmodule

// ### halfbridge_ctrl_model.sv
/*
 * Controller model: PWM cycle marker, leg reset pulses, pin pull-ups.
 * Assumes the bench asks for one reset pulse at a time.
 */
`timescale 1ns/1ps
module halfbridge_ctrl_model #(
    parameter int PERIOD = 32,
    parameter int WAIT   = 8,
    parameter int LOW    = 10
) (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       cycle_run_in,
    input  wire logic       pulse_req_in,
    input  wire logic [2:0] pulse_mask_in,
    input  wire logic       fault_n_in,
    input  wire logic       fault_oe_in,
    input  wire logic       warn_n_in,
    input  wire logic       warn_oe_in,
    output logic            pwm_cycle_out,
    output logic [2:0]      bridge_reset_n_out,
    output logic            busy_out,
    output logic            fault_line_out,
    output logic            warn_line_out
);
    logic [7:0] per;
    logic [7:0] cnt;
    logic [2:0] mask;
    // released open-drain pins read high through the pull-ups
    assign fault_line_out = fault_oe_in ? fault_n_in : 1'b1;
    assign warn_line_out  = warn_oe_in ? warn_n_in : 1'b1;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            per <= 8'h00;
            cnt <= 8'h00;
            mask <= 3'h0;
            pwm_cycle_out <= 1'b0;
            bridge_reset_n_out <= 3'h7;
            busy_out <= 1'b0;
        end else begin
            per <= (per == 8'(PERIOD - 1)) ? 8'h00 : per + 8'h01;
            // marker stays low unless the bench lets cycles run
            pwm_cycle_out <= cycle_run_in && (per < 8'h04);
            if (!busy_out && pulse_req_in) begin
                busy_out <= 1'b1;
                cnt <= 8'h00;
                mask <= pulse_mask_in;
            end else if (busy_out) begin
                cnt <= cnt + 8'h01;
                // shortened stand-in for the one second wait
                if (cnt == 8'(WAIT - 1)) begin
                    bridge_reset_n_out <= ~mask;
                end
                if (cnt == 8'(WAIT + LOW - 1)) begin
                    bridge_reset_n_out <= 3'h7;
                    busy_out <= 1'b0;
                end
            end
        end
    end
endmodule

// ### halfbridge_fault_protection_tb_top.sv
/*
 * Self-checking bench for the half-bridge protection core.
 * Assumes the controller model for cycle marker and leg resets.
 */
`timescale 1ns/1ps
module halfbridge_fault_protection_tb_top;
    import halfbridge_fault_pkg::*;
    logic        clk_in, reset_n_in, mode, temp_warn, temp_sd;
    logic        supply_ok, power_good, cycle_run, req;
    logic [2:0]  pwm_high, pwm_low, oc_high, oc_low, short_hit, mask, m;
    logic [2:0]  gate_high_out, gate_low_out, event_out, limiting_out;
    logic [2:0]  bridge_reset_n;
    logic        pwm_cycle, busy, thermal, guard, fault_n, fault_oe;
    logic        warn_n, warn_oe, fault_line, warn_line;
    logic [31:0] rnd;
    integer      seed, bad_count, checks_done;
    wire  [2:0]  pins = {fault_line, warn_line, guard};

    halfbridge_fault_protection DUT (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .pwm_high_in(pwm_high),
        .pwm_low_in(pwm_low), .bridge_reset_n_in(bridge_reset_n),
        .pwm_cycle_in(pwm_cycle), .cycle_limit_mode_in(mode),
        .oc_high_in(oc_high), .oc_low_in(oc_low),
        .short_hit_in(short_hit), .temp_warn_in(temp_warn),
        .temp_shutdown_in(temp_sd), .supply_ok_in(supply_ok),
        .power_good_in(power_good), .gate_high_out(gate_high_out),
        .gate_low_out(gate_low_out), .overcurrent_event_out(event_out),
        .limiting_out(limiting_out), .thermal_shutdown_out(thermal),
        .undervoltage_guard_out(guard), .fault_n_out(fault_n),
        .fault_oe_out(fault_oe), .heat_warning_n_out(warn_n),
        .heat_warning_oe_out(warn_oe));
    halfbridge_ctrl_model ctrl (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .cycle_run_in(cycle_run), .pulse_req_in(req),
        .pulse_mask_in(mask), .fault_n_in(fault_n),
        .fault_oe_in(fault_oe), .warn_n_in(warn_n), .warn_oe_in(warn_oe),
        .pwm_cycle_out(pwm_cycle), .bridge_reset_n_out(bridge_reset_n),
        .busy_out(busy), .fault_line_out(fault_line),
        .warn_line_out(warn_line));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic stop_test();
        $display("mismatches %0d checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %b want %b", $time, seen, exp);
        end
    endtask

    // three edges of latency plus margin, sampled off the edge
    task automatic settle();
        repeat (6) @(negedge clk_in);
    endtask

    task automatic wait_until_clear(input logic [2:0] lines);
        int n;
        n = 0;
        while (n < 200 && (bridge_reset_n & lines) != lines) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 200) begin
            bad_count++;
            stop_test();
        end
    endtask

    task automatic pulse(input logic [2:0] legs);
        @(posedge clk_in);
        req <= 1'b1;
        mask <= legs;
        @(posedge clk_in);
        req <= 1'b0;
        repeat (12) @(negedge clk_in);
        chk(gate_high_out & legs, 3'h0);
        chk(gate_low_out & legs, 3'h0);
        wait_until_clear(3'h7);
        settle();
    endtask

    function automatic logic [2:0] want_high(input logic [2:0] h,
                                             input logic [2:0] l);
        return h & ~l;
    endfunction

    initial begin
        seed = 5695;
        {bad_count, checks_done} = 0;
        {reset_n_in, mode, temp_warn, temp_sd, supply_ok} = 0;
        {power_good, cycle_run, req} = 0;
        {pwm_high, pwm_low, oc_high, oc_low, short_hit, mask} = 0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        settle();
        chk(gate_high_out | gate_low_out, 3'h0);
        chk(pins, 3'b011);
        @(posedge clk_in);
        supply_ok <= 1'b1;
        power_good <= 1'b1;
        settle();
        chk(pins, 3'b110);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_in);
            rnd = $random(seed);
            pwm_high <= rnd[2:0];
            pwm_low <= rnd[5:3];
            mode <= rnd[6];
            settle();
            chk(gate_high_out, want_high(pwm_high, pwm_low));
            chk(gate_low_out, want_high(pwm_low, pwm_high));
        end
        for (int l = 0; l < 3; l++) begin
            m = 3'h1 << l;
            @(posedge clk_in);
            {mode, pwm_high, pwm_low} <= {1'b0, 3'h7, 3'h0};
            if (l == 1) oc_high <= m;
            else oc_low <= m;
            settle();
            chk(event_out, m);
            chk(gate_high_out, ~m);
            chk(pins, 3'b010);
            @(posedge clk_in);
            {oc_high, oc_low} <= 6'h00;
            settle();
            chk(event_out, m);
            pulse(m);
            chk(event_out, 3'h0);
            chk(pins, 3'b110);
            rnd = $random(seed);
            m = (rnd[1:0] == 2'h3) ? 3'h4 : 3'h1 << rnd[1:0];
            @(posedge clk_in);
            mode <= 1'b1;
            oc_high <= m;
            settle();
            chk(gate_high_out, ~m);
            chk(gate_low_out, m);
            chk(limiting_out, m);
            chk(event_out, 3'h0);
            @(posedge clk_in);
            oc_high <= 3'h0;
            settle();
            chk(limiting_out, m);
            @(posedge clk_in);
            cycle_run <= 1'b1;
            repeat (40) @(negedge clk_in);
            chk(limiting_out, 3'h0);
            chk(gate_high_out, 3'h7);
            @(posedge clk_in);
            {cycle_run, pwm_high, pwm_low, oc_low} <= {1'b0, 3'h0, 3'h7, m};
            settle();
            chk(gate_low_out, ~m);
            chk(gate_high_out, 3'h0);
            @(posedge clk_in);
            {cycle_run, oc_low, short_hit} <= {1'b1, 3'h0, m};
            settle();
            @(posedge clk_in);
            short_hit <= 3'h0;
            repeat (40) @(negedge clk_in);
            chk(event_out, m);
            chk(gate_low_out, ~m);
            pulse(m);
            chk(event_out, 3'h0);
            cycle_run <= 1'b0;
        end
        @(posedge clk_in);
        temp_warn <= 1'b1;
        settle();
        chk(pins, 3'b100);
        @(posedge clk_in);
        temp_sd <= 1'b1;
        settle();
        chk({thermal, pins[2:1]}, 3'b100);
        chk(gate_low_out | gate_high_out, 3'h0);
        @(posedge clk_in);
        {temp_sd, temp_warn} <= 2'b00;
        pulse(3'h3);
        chk({2'h0, thermal}, 3'h1);
        pulse(3'h4);
        chk({thermal, pins[2:1]}, 3'b011);
        chk(pins, 3'b110);
        @(posedge clk_in);
        supply_ok <= 1'b0;
        settle();
        chk(gate_low_out, 3'h0);
        chk(pins, 3'b011);
        @(posedge clk_in);
        {supply_ok, oc_low} <= {1'b1, 3'h2};
        settle();
        chk(pins, 3'b110);
        chk(gate_low_out, 3'h5);
        @(posedge clk_in);
        {mode, power_good} <= 2'b00;
        settle();
        chk(event_out, 3'h0);
        chk(pins, 3'b011);
        @(posedge clk_in);
        {power_good, oc_low} <= {1'b1, 3'h0};
        settle();
        chk(pins, 3'b110);
        // leg 1 drives its low gate here, so the reset really blocks it
        pulse(3'h2);
        chk(gate_low_out, 3'h7);
        stop_test();
    end

    initial begin
        repeat (50000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end
endmodule
